// ---- external_request_pin_logic.sv ----
// pin-level request logic: external requests, cascade pins, timer pins, mux pins
//
// Summary of operation
// - external request inputs are active high, edge or level recognised per line.
// - recognised enabled request raises interrupt and reports that line's vector.
// - lines zero to three behave like line four, own vector only.
// - cascade mode turns line three and two pins into acknowledges one, zero.
// - in slave mode line three pin outputs our interrupt request.
// - timer inputs synchronised; rising edges are counted in external count mode.
// - timer outputs give single pulse or duty waveform, float in hold, reset.
// - transfer request inputs active high, synchronised level, never latched.
// - unused channel's request pin acts as extra interrupt request.
// - extra interrupt inputs are level only, pending while high.
// - each of 32 mux pins becomes general purpose via mode, direction bits.
// - reset pulls pins 1,10,22,23 down, keeps 4..9, pulls others up.
// - non-maskable request recognised on rising edge, own vector; here it is still gated by mask bit ST_NMI like the other lines.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module external_request_pin_logic
  import pin_req_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dedicated request pins
  input wire logic ext_request_line0,
  input wire logic ext_request_line1,
  input wire logic ext_request_line3In,
  output logic ext_request_line3Out,
  output logic ext_request_line3Oe,
  input wire logic nmiRequest,
  input wire logic busHold,
  // 32 multiplexed pins
  input wire logic [31:0] general_purpose_pinIn,
  output logic [31:0] general_purpose_pinOut,
  output logic [31:0] general_purpose_pinOe,
  output logic [31:0] pullUpEn,
  output logic [31:0] pullDownEn,
  // interrupt to the core
  output logic interrupt
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] pinMode_q;
  logic [31:0] pinDir_q;
  logic [31:0] pinOut_q;
  logic [31:0] tmrCfg_q [2];
  logic [15:0] tmrCnt_q [2];
  logic [1:0] tmrDone_q;
  logic [1:0] tmrWave;
  logic [7:0] awAddr_q;
  logic awHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHave_q;
  logic [1:0] ackPin_q;
  logic nmiPrev_q;
  logic selPrev_q;
  logic [1:0] tinPrev_q;
  logic [7:0] divCnt_q;
  logic divTick;

  logic [NUM_SYNC-1:0] syncIn;
  logic [NUM_SYNC-1:0] syncOut;
  logic [31:0] gpS;
  logic [31:0] funcIn;
  logic line0S;
  logic line1S;
  logic line3S;
  logic nmiS;
  logic holdS;
  logic [1:0] tinS;
  logic [1:0] xferS;
  logic [1:0] xferFree;
  logic doWrite;
  logic wrHit;
  logic [6:0] ackVec;
  logic [31:0] events;
  logic [31:0] active;
  logic [3:0] topLine;
  logic topValid;

  req_if req ();

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : applyStrb

  function automatic logic isMapped(input logic [7:0] addr);
    return (addr[1:0] == 2'b00) && (addr <= OFS_TMR_CNT);
  endfunction : isMapped

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  assign syncIn = {busHold, nmiRequest, ext_request_line3In, ext_request_line1,
                   ext_request_line0, general_purpose_pinIn};

  pin_sync #(.W(NUM_SYNC)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async(syncIn),
    .synced(syncOut)
  );

  assign gpS = syncOut[31:0];
  assign line0S = syncOut[32];
  assign line1S = syncOut[33];
  assign line3S = syncOut[34];
  assign nmiS = syncOut[35];
  assign holdS = syncOut[36];
  // a pin in general-purpose mode no longer feeds its function
  assign funcIn = gpS & ~pinMode_q;
  assign tinS = {funcIn[PIN_TIN1], funcIn[PIN_TIN0]};
  assign xferS = {funcIn[PIN_XFER1], funcIn[PIN_XFER0]};
  assign xferFree = ctrl_q[CTRL_XFER_FREE_LSB +: 2];

  // ---------------------------------------------------------------
  // request recognition
  // ---------------------------------------------------------------
  // line 3 and line 2 pins carry requests only when not used as outputs
  always_comb begin
    req.level[0] = line0S;
    req.level[1] = line1S & ~ctrl_q[CTRL_SLAVE];                       // select in slave mode
    req.level[2] = funcIn[PIN_LINE2] & ~ctrl_q[CTRL_CASCADE];
    req.level[3] = line3S & ~ctrl_q[CTRL_CASCADE] & ~ctrl_q[CTRL_SLAVE];
    req.level[4] = funcIn[PIN_LINE4];
    req.level[5] = xferS[0] & xferFree[0];
    req.level[6] = xferS[1] & xferFree[1];
  end
  assign req.edgeMode = {2'b00, ctrl_q[CTRL_EDGE_LSB +: 5]};
  assign req.ack = ackVec;

  req_detect u_detect (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req)
  );

  // ---------------------------------------------------------------
  // edge tracking for nmi, select and timer inputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      nmiPrev_q <= 1'b0;
      selPrev_q <= 1'b0;
      tinPrev_q <= 2'b00;
    end else begin
      nmiPrev_q <= nmiS;
      selPrev_q <= line1S;
      tinPrev_q <= tinS;
    end
  end

  // events feeding the sticky status; pending lines re-set while they stay pending
  always_comb begin
    events = '0;
    events[NUM_LINES-1:0] = req.pending;
    events[ST_NMI] = nmiS & ~nmiPrev_q;
    events[ST_TIN_LSB +: 2] = tinS & ~tinPrev_q;
    // type on the bus only counts once line zero is already up
    events[ST_SELECT] = ctrl_q[CTRL_SLAVE] & line1S & ~selPrev_q & line0S;
  end

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  assign wrHit = doWrite && isMapped(awAddr_q);

  // address and data may arrive in either order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHave_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_q <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awAddr_q) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= 32'h00000000;
      mask_q <= 32'h00000000;
      pinMode_q <= PIN_MODE_RST;
      pinDir_q <= PIN_DIR_RST;
      pinOut_q <= 32'h00000000;
      tmrCfg_q[0] <= 32'h00000000;
      tmrCfg_q[1] <= 32'h00000000;
    end else if (wrHit) begin
      case (awAddr_q)
        OFS_CTRL: ctrl_q <= applyStrb(ctrl_q, wData_q, wStrb_q) & CTRL_WMASK;
        OFS_MASK: mask_q <= applyStrb(mask_q, wData_q, wStrb_q) & ST_WMASK;
        OFS_PIN_MODE: pinMode_q <= applyStrb(pinMode_q, wData_q, wStrb_q);
        OFS_PIN_DIR: pinDir_q <= applyStrb(pinDir_q, wData_q, wStrb_q);
        OFS_PIN_OUT: pinOut_q <= applyStrb(pinOut_q, wData_q, wStrb_q);
        OFS_TMR0: tmrCfg_q[0] <= applyStrb(tmrCfg_q[0], wData_q, wStrb_q);
        OFS_TMR1: tmrCfg_q[1] <= applyStrb(tmrCfg_q[1], wData_q, wStrb_q);
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event in the same cycle stays set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= 32'h00000000;
    end else if (wrHit && awAddr_q == OFS_STATUS && wStrb_q[1:0] != 2'b00) begin
      status_q <= (status_q & ~(wData_q & ST_WMASK)) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // writing the vector register acknowledges one line by number
  always_comb begin
    ackVec = '0;
    if (wrHit && awAddr_q == OFS_VECTOR && wStrb_q[0] && wData_q[3:0] < 4'd7) begin
      ackVec[wData_q[2:0]] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupt and vector
  // ---------------------------------------------------------------
  assign active = status_q & mask_q;
  assign interrupt = |active;

  // nmi outranks every maskable line, then the lowest line number wins
  always_comb begin
    topLine = 4'd0;
    topValid = 1'b0;
    if (active[ST_NMI]) begin
      topLine = 4'd7;
      topValid = 1'b1;
    end else begin
      for (int i = NUM_LINES - 1; i >= 0; i--) begin
        if (active[i]) begin
          topLine = i[3:0];
          topValid = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // cascade acknowledge and slave request pin
  // ---------------------------------------------------------------
  // one-cycle acknowledge pulse when software acks line one or zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ackPin_q <= 2'b00;
    end else begin
      ackPin_q <= ctrl_q[CTRL_CASCADE] ? ackVec[1:0] : 2'b00;
    end
  end

  // slave mode wins over cascade for the line three pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_request_line3Out <= 1'b0;
      ext_request_line3Oe <= 1'b0;
    end else if (ctrl_q[CTRL_SLAVE]) begin
      ext_request_line3Out <= interrupt;
      ext_request_line3Oe <= 1'b1;
    end else begin
      ext_request_line3Out <= ackPin_q[1];
      ext_request_line3Oe <= ctrl_q[CTRL_CASCADE];
    end
  end

  // ---------------------------------------------------------------
  // timers: tick divider, counters and waveforms
  // ---------------------------------------------------------------
  assign divTick = (divCnt_q == 8'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divTick ? 8'h00 : divCnt_q + 8'h01;
    end
  end

  // cfg low half is the period, high half the high time of the waveform
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmrCnt_q[0] <= 16'h0000;
      tmrCnt_q[1] <= 16'h0000;
      tmrDone_q <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (!ctrl_q[CTRL_TMR_RUN_LSB + t]) begin
          tmrCnt_q[t] <= 16'h0000;
          tmrDone_q[t] <= 1'b0;
        end else if (!tmrDone_q[t] && (ctrl_q[CTRL_TMR_EXT_LSB + t] ? events[ST_TIN_LSB + t]
                                       : divTick)) begin
          if (tmrCnt_q[t] >= tmrCfg_q[t][15:0]) begin
            tmrCnt_q[t] <= 16'h0000;
            tmrDone_q[t] <= ~ctrl_q[CTRL_TMR_CONT_LSB + t];
          end else begin
            tmrCnt_q[t] <= tmrCnt_q[t] + 16'h0001;
          end
        end
      end
    end
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tmrWave[t] = ctrl_q[CTRL_TMR_RUN_LSB + t] & ~tmrDone_q[t] &
                   (tmrCnt_q[t] < tmrCfg_q[t][31:16]);
    end
  end

  // ---------------------------------------------------------------
  // mux pin drive and pulls
  // ---------------------------------------------------------------
  // registered so pins stay quiet through reset; timer outputs float in hold
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      general_purpose_pinOut <= 32'h00000000;
      general_purpose_pinOe <= 32'h00000000;
      pullUpEn <= PIN_MODE_RST & ~PULL_DOWN_SET;
      pullDownEn <= PULL_DOWN_SET;
    end else begin
      general_purpose_pinOut <= pinOut_q & pinMode_q;
      general_purpose_pinOe <= pinMode_q & pinDir_q;
      if (!pinMode_q[PIN_WAVE0]) begin
        general_purpose_pinOut[PIN_WAVE0] <= tmrWave[0];
        general_purpose_pinOe[PIN_WAVE0] <= ~holdS;
      end
      if (!pinMode_q[PIN_WAVE1]) begin
        general_purpose_pinOut[PIN_WAVE1] <= tmrWave[1];
        general_purpose_pinOe[PIN_WAVE1] <= ~holdS;
      end
      if (!pinMode_q[PIN_LINE2] && ctrl_q[CTRL_CASCADE]) begin
        general_purpose_pinOut[PIN_LINE2] <= ackPin_q[0];
        general_purpose_pinOe[PIN_LINE2] <= 1'b1;
      end
      pullUpEn <= pinMode_q & ~pinDir_q & ~PULL_DOWN_SET;
      pullDownEn <= pinMode_q & ~pinDir_q & PULL_DOWN_SET;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // data held stable until the master takes it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= ctrl_q;
        OFS_STATUS: s_axi_rdata <= status_q;
        OFS_MASK: s_axi_rdata <= mask_q;
        OFS_VECTOR: s_axi_rdata <= {24'h000000, topValid, 3'b000, topLine};
        OFS_PIN_MODE: s_axi_rdata <= pinMode_q;
        OFS_PIN_DIR: s_axi_rdata <= pinDir_q;
        OFS_PIN_OUT: s_axi_rdata <= pinOut_q;
        OFS_PIN_IN: s_axi_rdata <= gpS;
        OFS_TMR0: s_axi_rdata <= tmrCfg_q[0];
        OFS_TMR1: s_axi_rdata <= tmrCfg_q[1];
        OFS_TMR_CNT: s_axi_rdata <= {tmrCnt_q[1], tmrCnt_q[0]};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : external_request_pin_logic

// ---- pin_req_pkg.sv ----
// shared constants for the external request pin logic
package pin_req_pkg;

  // ---------------------------------------------------------------
  // request lines: 0..4 external, 5..6 extra (transfer request pins)
  // ---------------------------------------------------------------
  localparam int NUM_LINES = 7;
  localparam int NUM_SYNC = 37;             // 32 mux pins + lines 0,1,3 + nmi + hold
  localparam logic [NUM_LINES-1:0] LEVEL_ONLY = 7'h60;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_VECTOR = 8'h0C;
  localparam logic [7:0] OFS_PIN_MODE = 8'h10;
  localparam logic [7:0] OFS_PIN_DIR = 8'h14;
  localparam logic [7:0] OFS_PIN_OUT = 8'h18;
  localparam logic [7:0] OFS_PIN_IN = 8'h1C;
  localparam logic [7:0] OFS_TMR0 = 8'h20;
  localparam logic [7:0] OFS_TMR1 = 8'h24;
  localparam logic [7:0] OFS_TMR_CNT = 8'h28;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_EDGE_LSB = 0;         // 5 bits, 1 = edge triggered
  localparam int CTRL_CASCADE = 5;
  localparam int CTRL_SLAVE = 6;
  localparam int CTRL_XFER_FREE_LSB = 7;    // 2 bits, channel unused
  localparam int CTRL_TMR_EXT_LSB = 9;      // 2 bits, count timer input edges
  localparam int CTRL_TMR_CONT_LSB = 11;    // 2 bits, continuous waveform
  localparam int CTRL_TMR_RUN_LSB = 13;     // 2 bits
  localparam logic [31:0] CTRL_WMASK = 32'h00007FFF;

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  localparam int ST_NMI = 7;
  localparam int ST_TIN_LSB = 8;
  localparam int ST_SELECT = 10;
  localparam logic [31:0] ST_WMASK = 32'h000007FF;

  // ---------------------------------------------------------------
  // mux pin positions and reset values
  // ---------------------------------------------------------------
  localparam int PIN_TIN1 = 0;
  localparam int PIN_WAVE1 = 1;
  localparam int PIN_WAVE0 = 10;
  localparam int PIN_TIN0 = 11;
  localparam int PIN_XFER0 = 12;
  localparam int PIN_XFER1 = 13;
  localparam int PIN_LINE4 = 30;
  localparam int PIN_LINE2 = 31;
  localparam logic [31:0] PIN_MODE_RST = 32'hFFFFFC0F;  // pins 4..9 keep function
  localparam logic [31:0] PIN_DIR_RST = 32'h00000000;
  localparam logic [31:0] PULL_DOWN_SET = 32'h00C00402; // pins 1, 10, 22, 23

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_NS = 20;       // internal timer tick
  localparam int TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

endpackage : pin_req_pkg

// ---- req_if.sv ----
// carrier between the control logic and the request detector
`timescale 1ns/100ps
interface req_if;
  import pin_req_pkg::*;
  logic [NUM_LINES-1:0] level;
  logic [NUM_LINES-1:0] edgeMode;
  logic [NUM_LINES-1:0] ack;
  logic [NUM_LINES-1:0] pending;
  modport ctrl (output level, output edgeMode, output ack, input pending);
  modport det (input level, input edgeMode, input ack, output pending);
endinterface : req_if

// ---- pin_sync.sv ----
// three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] st1_q;
  logic [W-1:0] st2_q;
  logic [W-1:0] st3_q;

  // stage one feeds stage two only, metastability settles there
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
    end else begin
      st1_q <= async;
      st2_q <= st1_q;
      st3_q <= st2_q;
    end
  end

  // accept per bit only when the two later stages match
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      synced <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (st2_q[i] == st3_q[i]) begin
          synced[i] <= st3_q[i];
        end
      end
    end
  end

endmodule : pin_sync

// ---- req_detect.sv ----
// edge or level recognition of the request lines
`timescale 1ns/100ps
module req_detect
  import pin_req_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // request lines
  req_if.det req
);

  logic [NUM_LINES-1:0] prev_q;
  logic [NUM_LINES-1:0] latch_q;
  logic [NUM_LINES-1:0] useEdge;

  // extra lines never latch, whatever software asks
  assign useEdge = req.edgeMode & ~LEVEL_ONLY;

  // edge latch; a new edge in the ack cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_q <= '0;
      latch_q <= '0;
    end else begin
      prev_q <= req.level;
      latch_q <= (latch_q & ~req.ack) | (req.level & ~prev_q);
    end
  end

  // level mode follows the pin, so a dropped level drops the request
  assign req.pending = (useEdge & latch_q) | (~useEdge & req.level);

endmodule : req_detect

// ---- pin_req_checker_assertions.sv ----
// port-level checks on the external request pin logic
`timescale 1ns/100ps
module pin_req_checker
  import pin_req_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic busHold,
  input wire logic [31:0] general_purpose_pinOe,
  input wire logic ext_request_line3Oe,
  input wire logic [31:0] pullUpEn,
  input wire logic [31:0] pullDownEn,
  input wire logic interrupt
);
  // ----------------
  // pads and register answers
  // ----------------
  a_pull_down_rst: assert property (@(posedge mclk) !rst_n |=> pullDownEn == PULL_DOWN_SET)
    else $error("pull-down wrong");
  a_pull_up_rst: assert property (@(posedge mclk)
    !rst_n |=> pullUpEn == (PIN_MODE_RST & ~PULL_DOWN_SET)) else $error("pull-up wrong");
  a_float_rst: assert property (@(posedge mclk) !rst_n |=>
    general_purpose_pinOe == 32'h0 && !ext_request_line3Oe && !interrupt)
    else $error("driven in reset");
  // hold needs the synchroniser delay before the wave pins let go
  a_hold_float: assert property (@(posedge mclk) disable iff (!rst_n) busHold [*8] |->
    !general_purpose_pinOe[PIN_WAVE0] && !general_purpose_pinOe[PIN_WAVE1])
    else $error("wave driven in hold");
  a_write_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_write_release: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response held");
  a_read_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_read_release: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data held");
endmodule : pin_req_checker

bind external_request_pin_logic pin_req_checker chk_u (.*);

// ---- req_source_model.sv ----
// far-side sources: request lines, nmi source and transfer requesters
`timescale 1ns/100ps
module req_source_model (
  // clock
  input wire logic mclk,
  // sources asking, from the sequence
  input wire logic [7:0] want,
  // request levels on the pins
  output logic [7:0] reqOut = 8'h00
);
  // ----------------
  // request drive
  // ----------------
  // a source keeps its line up until released after ack or service
  // registered, so an nmi assertion lasts one whole clock at least
  always @(posedge mclk) begin
    reqOut <= want;
  end
endmodule : req_source_model

// ---- tb_top.sv ----
// self-checking bench for the external request pin logic
`timescale 1ns/100ps
module tb_top;
  import pin_req_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic mclk = 0, rst_n = 0, busHold = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, want = 8'h00, reqOut;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, general_purpose_pinOut, general_purpose_pinOe;
  logic [31:0] pullUpEn, pullDownEn, rdVal;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, interrupt;
  logic ext_request_line3Out, ext_request_line3Oe;
  int badCount = 0, numChecks = 0;
  // pads rest at their pull level unless a source or the design drives them
  wire [31:0] resting = ~PULL_DOWN_SET;
  wire [31:0] padLevel = {reqOut[2], reqOut[4], resting[29:14], reqOut[6], reqOut[5], resting[11:0]};
  wire [31:0] general_purpose_pinIn = (general_purpose_pinOe & general_purpose_pinOut)
    | (~general_purpose_pinOe & padLevel);
  wire ext_request_line3In = ext_request_line3Oe ? ext_request_line3Out : reqOut[3];
  wire ext_request_line0 = reqOut[0];
  wire ext_request_line1 = reqOut[1];
  wire nmiRequest = reqOut[7];
  external_request_pin_logic dut_u (.*);
  req_source_model src_u (.mclk(mclk), .want(want), .reqOut(reqOut));
  initial forever #2.5 mclk = ~mclk;
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic testDone();
    if (badCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : testDone
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel lets go only at its own taking edge
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic waitIrq(input logic v);
    for (int i = 0; i < 40 && interrupt !== v; i++) @(posedge mclk);
    chk(32'(interrupt), 32'(v));
  endtask : waitIrq
  // raise one source, see its vector, acknowledge, drop and clear it
  task automatic oneLine(input int n);
    wr(OFS_MASK, 32'h1 << n);
    want[n] <= 1'b1;
    waitIrq(1'b1);
    rd(OFS_VECTOR);
    chk(rdVal, 32'h80 | 32'(n));
    wr(OFS_VECTOR, 32'(n));
    want[n] <= 1'b0;
    repeat (8) @(posedge mclk);
    wr(OFS_STATUS, 32'h1 << n);
    waitIrq(1'b0);
  endtask : oneLine
  // ----------------
  // sequence and watchdog
  // ----------------
  initial begin
    logic seen;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(pullDownEn, PULL_DOWN_SET);
    chk(pullUpEn, PIN_MODE_RST & ~PULL_DOWN_SET);
    rd(OFS_PIN_MODE);
    chk(rdVal, PIN_MODE_RST);
    rd(8'h40);
    chk(32'(rdResp), 32'h2);
    wr(OFS_PIN_MODE, 32'h0);
    wr(OFS_CTRL, 32'h19F);
    for (int n = 0; n < 8; n++) oneLine(n);
    // level line: a clear while still asked for does not stick
    wr(OFS_CTRL, 32'h180);
    wr(OFS_MASK, 32'h1);
    want[0] <= 1'b1;
    waitIrq(1'b1);
    wr(OFS_STATUS, 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'(interrupt), 32'h1);
    wr(OFS_CTRL, 32'h1C0);
    repeat (3) @(posedge mclk);
    chk(32'({ext_request_line3Oe, ext_request_line3Out}), 32'h3);
    want[1] <= 1'b1; // line zero is already up
    repeat (8) @(posedge mclk);
    rd(OFS_STATUS);
    chk(32'(rdVal[ST_SELECT]), 32'h1);
    want[1:0] <= 2'b00;
    repeat (8) @(posedge mclk);
    wr(OFS_STATUS, 32'h1);
    waitIrq(1'b0);
    wr(OFS_CTRL, 32'h20);
    for (int n = 0; n < 2; n++) begin
      wr(OFS_VECTOR, 32'(n));
      seen = 1'b0;
      repeat (6) @(posedge mclk) seen |= n ? ext_request_line3Oe & ext_request_line3Out
        : general_purpose_pinOe[PIN_LINE2] & general_purpose_pinOut[PIN_LINE2];
      chk(32'(seen), 32'h1);
    end
    busHold <= 1'b1;
    repeat (10) @(posedge mclk);
    busHold <= 1'b0;
    wr(OFS_PIN_MODE, 32'h2);
    wr(OFS_PIN_DIR, 32'h2);
    wr(OFS_PIN_OUT, 32'h2);
    repeat (8) @(posedge mclk);
    rd(OFS_PIN_IN);
    chk(rdVal, (resting & 32'h3FFFCFFF) | 32'h2);
    testDone();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    badCount++;
    testDone();
  end
endmodule : tb_top
